/* File: logic/eeprom_params.svh */
// Offsets, field positions, reset values and timing counts for the serial EEPROM link.
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// ****************************************************************
// Clock and link timing
// ****************************************************************
`define CLK_PERIOD_NS    4
`define SCK_HALF_NS      64
`define SCK_HALF_CYC     ((`SCK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_CYCLES_DEF  1000

// ****************************************************************
// Array geometry and opcode fields
// ****************************************************************
`define ADDR_BITS        10
`define PAGE_BITS        5
`define OPC_HIGH         4'h0
`define WRITE_ENABLE_CMD  3'h6
`define WRITE_DISABLE_CMD 3'h4
`define STATUS_READ_CMD   3'h5
`define STATUS_WRITE_CMD  3'h1
`define ARRAY_READ_CMD    3'h3
`define ARRAY_WRITE_CMD   3'h2

// ****************************************************************
// Status byte layout and reset values
// ****************************************************************
`define ST_PROTECT_PIN_ENABLE 7
`define ST_BLOCK_PROTECT_HI   3
`define ST_BLOCK_PROTECT_LO   2
`define ST_WRITE_LATCH        1
`define ST_BUSY               0
`define ST_BUSY_VALUE         8'hFF
`define PROTECT_RESET         2'h0

// ****************************************************************
// Controller register map (byte addresses) and fields
// ****************************************************************
`define REG_CTRL     5'h00
`define REG_ADDR     5'h04
`define REG_TXDATA   5'h08
`define REG_RXDATA   5'h0C
`define REG_STATUS   5'h10
`define REG_PIN      5'h14
`define CTRL_ADDR_EN 8
`define CTRL_CNT_LSB 9
`define CTRL_CNT_MSB 11
`define MAX_BITS     56

`endif

/* File: logic/eeprom_pkg.sv */
// Shared types of the serial EEPROM device and its controller.
package eeprom_pkg;
  typedef enum logic [2:0] {
    D_IDLE, D_OPCODE, D_ADDR, D_RDATA, D_WDATA, D_SDATA, D_SOUT, D_IGNORE
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TRAIL, H_GAP
  } host_state_t;
endpackage : eeprom_pkg

/* File: logic/spi_link_if.sv */
// Four-wire serial link plus write-protect pin between controller and EEPROM.
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic wp_n;
  logic so;
  logic so_oe;
  logic so_line;

  // The data-out wire floats when undriven; a pull-up gives it a defined level.
  assign so_line = so_oe ? so : 1'b1;

  modport device (input cs_n, input sck, input si, input wp_n, output so, output so_oe);
  modport host   (output cs_n, output sck, output si, output wp_n, input so_line);
endinterface : spi_link_if

/* File: logic/eeprom_device.sv */
// Serial EEPROM slave: command decode, array read/write, protection and busy cycle.
`include "eeprom_params.svh"

module eeprom_device #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES_DEF
) (
  input  wire logic      REF_CLK,
  input  wire logic      RESET,
  spi_link_if.device     LINK,
  output logic           PROG_BUSY
);
  localparam int AW = `ADDR_BITS;
  localparam int PW = `PAGE_BITS;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] cs_sync;
  logic [1:0] sck_sync;
  logic [1:0] si_sync;
  logic [1:0] wp_sync;
  logic       cs_q;
  logic       sck_q;

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cs_sync  <= 2'h3;
      sck_sync <= 2'h0;
      si_sync  <= 2'h0;
      wp_sync  <= 2'h3;
      cs_q     <= 1'b1;
      sck_q    <= 1'b0;
    end else begin
      cs_sync  <= {cs_sync[0], LINK.cs_n};
      sck_sync <= {sck_sync[0], LINK.sck};
      si_sync  <= {si_sync[0], LINK.si};
      wp_sync  <= {wp_sync[0], LINK.wp_n};
      cs_q     <= cs_sync[1];
      sck_q    <= sck_sync[1];
    end
  end

  wire cs_n     = cs_sync[1];
  wire si       = si_sync[1];
  wire wp_n     = wp_sync[1];
  wire cs_fall  = ~cs_n & cs_q;
  wire cs_rise  = cs_n & ~cs_q;
  wire sck_rise = sck_sync[1] & ~sck_q & ~cs_n;
  wire sck_fall = ~sck_sync[1] & sck_q & ~cs_n;

  // ****************************************************************
  // State
  // ****************************************************************
  eeprom_pkg::dev_state_t state;
  logic [2:0]         bit_cnt;
  logic [7:0]         shift;
  logic [15:0]        addr;
  logic               addr_second;
  logic               read_op;
  logic               got_byte;
  logic               wel;
  logic [1:0]         bp;
  logic               ppe;
  logic               busy;
  logic               prog_status;
  logic [31:0]        prog_cnt;
  logic [7:0]         pend_status;
  logic [7:0]         out_byte;
  logic [2:0]         out_idx;
  logic               so;
  logic               so_oe;
  logic [7:0]         mem [0:(1 << AW) - 1];
  logic [7:0]         pbuf [0:(1 << PW) - 1];
  logic [(1 << PW) - 1:0] pval;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  wire [7:0]    rx_byte    = {shift[6:0], si};
  wire          byte_done  = sck_rise & (bit_cnt == 3'h7);
  wire          hw_protect = ~wp_n & ppe;
  wire [AW-1:0] cur        = addr[AW-1:0];
  wire [AW-1:0] cur_next   = cur + 1'b1;
  wire [AW-1:0] new_addr   = {addr[AW-9:0], rx_byte};
  wire [PW-1:0] page_off   = addr[PW-1:0];
  wire          opc_valid  = rx_byte[7:4] == `OPC_HIGH;
  wire [2:0]    opc        = rx_byte[2:0];
  wire          prog_done  = busy & (prog_cnt == PROG_CYCLES - 1);
  wire          addr_prot  = (bp == 2'h3)
                           | (bp == 2'h2 & cur[AW-1])
                           | (bp == 2'h1 & (&cur[AW-1:AW-2]));
  wire [7:0]    status_byte = busy ? `ST_BUSY_VALUE
                                   : {ppe, 3'h0, bp, wel, 1'b0};
  wire          start_array = (state == eeprom_pkg::D_WDATA) & got_byte &
                              (bit_cnt == 3'h0) & wel;
  wire          start_status = (state == eeprom_pkg::D_SDATA) & got_byte &
                               (bit_cnt == 3'h0) & wel & ~hw_protect;

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state       <= eeprom_pkg::D_IDLE;
      bit_cnt     <= 3'h0;
      shift       <= 8'h00;
      addr        <= 16'h0000;
      addr_second <= 1'b0;
      read_op     <= 1'b0;
      got_byte    <= 1'b0;
      wel         <= 1'b0;
      bp          <= `PROTECT_RESET;
      ppe         <= 1'b0;
      busy        <= 1'b0;
      prog_status <= 1'b0;
      prog_cnt    <= 32'h0;
      pend_status <= 8'h00;
      out_byte    <= 8'h00;
      out_idx     <= 3'h7;
      so          <= 1'b0;
      so_oe       <= 1'b0;
      pval        <= '0;
    end else begin
      if (busy) begin
        prog_cnt <= prog_cnt + 32'h1;
      end
      if (prog_done) begin
        busy <= 1'b0;
        wel  <= 1'b0;
        if (prog_status) begin
          ppe <= pend_status[`ST_PROTECT_PIN_ENABLE];
          bp  <= pend_status[`ST_BLOCK_PROTECT_HI:`ST_BLOCK_PROTECT_LO];
        end
      end
      if (cs_rise) begin
        state <= eeprom_pkg::D_IDLE;
        so_oe <= 1'b0;
        if (start_array | start_status) begin
          busy        <= 1'b1;
          prog_cnt    <= 32'h0;
          prog_status <= start_status;
        end
      end else if (cs_fall) begin
        state    <= eeprom_pkg::D_OPCODE;
        bit_cnt  <= 3'h0;
        got_byte <= 1'b0;
      end else if (sck_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        shift   <= rx_byte;
        unique case (state)
          eeprom_pkg::D_OPCODE: begin
            if (byte_done) begin
              addr_second <= 1'b0;
              read_op     <= opc == `ARRAY_READ_CMD;
              state       <= eeprom_pkg::D_IGNORE;
              out_idx     <= 3'h7;
              if (opc_valid & opc == `STATUS_READ_CMD) begin
                state    <= eeprom_pkg::D_SOUT;
                out_byte <= status_byte;
              end else if (opc_valid & ~busy) begin
                unique case (opc)
                  `WRITE_ENABLE_CMD:  wel <= 1'b1;
                  `WRITE_DISABLE_CMD: wel <= 1'b0;
                  `STATUS_WRITE_CMD:  if (wel) state <= eeprom_pkg::D_SDATA;
                  `ARRAY_READ_CMD:    state <= eeprom_pkg::D_ADDR;
                  `ARRAY_WRITE_CMD:   if (wel) state <= eeprom_pkg::D_ADDR;
                  default:            state <= eeprom_pkg::D_IGNORE;
                endcase
              end
            end
          end
          eeprom_pkg::D_ADDR: begin
            if (byte_done) begin
              addr        <= {addr[7:0], rx_byte};
              addr_second <= 1'b1;
              if (addr_second & read_op) begin
                state    <= eeprom_pkg::D_RDATA;
                out_byte <= mem[new_addr];
              end else if (addr_second) begin
                state <= eeprom_pkg::D_WDATA;
                pval  <= '0;
              end
            end
          end
          eeprom_pkg::D_WDATA: begin
            if (byte_done) begin
              pbuf[page_off] <= rx_byte;
              pval[page_off] <= ~addr_prot & ~(hw_protect & addr_prot);
              got_byte       <= 1'b1;
              addr[PW-1:0]   <= page_off + 1'b1;
            end
          end
          eeprom_pkg::D_SDATA: begin
            if (byte_done) begin
              pend_status <= rx_byte;
              got_byte    <= 1'b1;
            end
          end
          eeprom_pkg::D_RDATA: begin
            out_idx <= out_idx - 3'h1;
            if (out_idx == 3'h0) begin
              addr[AW-1:0] <= cur_next;
              out_byte     <= mem[cur_next];
            end
          end
          eeprom_pkg::D_SOUT: begin
            out_idx <= out_idx - 3'h1;
            if (out_idx == 3'h0) begin
              out_byte <= status_byte;
            end
          end
          default: begin
          end
        endcase
      end else if (sck_fall & (state == eeprom_pkg::D_RDATA | state == eeprom_pkg::D_SOUT)) begin
        so    <= out_byte[out_idx];
        so_oe <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Array commit at the end of the busy cycle
  // ****************************************************************
  // The page buffer is committed only when the timer expires, so a read of the
  // array during programming is impossible and never sees a half-written page.
  always_ff @(posedge REF_CLK) begin
    if (prog_done & ~prog_status) begin
      for (int i = 0; i < (1 << PW); i++) begin
        if (pval[i]) begin
          mem[{addr[AW-1:PW], PW'(i)}] <= pbuf[i];
        end
      end
    end
  end

  assign LINK.so    = so;
  assign LINK.so_oe = so_oe;
  assign PROG_BUSY  = busy;
endmodule : eeprom_device

/* File: logic/spi_host.sv */
// SPI controller: Avalon-MM register slave that runs one EEPROM command per start.
`include "eeprom_params.svh"

module spi_host (
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic [4:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output logic [31:0]      READDATA,
  output logic             WAITREQUEST,
  spi_link_if.host         LINK
);
  localparam int HALF = `SCK_HALF_CYC;

  // ****************************************************************
  // Register slave
  // ****************************************************************
  logic [31:0] ctrl;
  logic [15:0] addr_reg;
  logic [31:0] txdata;
  logic [31:0] rxdata;
  logic        wp_level;
  logic        busy;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) old[b*8 +: 8] = nw[b*8 +: 8];
    end
    return old;
  endfunction : merge

  wire sel_ctrl  = ADDRESS == `REG_CTRL;
  wire stall     = WRITE & sel_ctrl & busy;
  wire accept    = (READ | WRITE) & WAITREQUEST & ~stall;
  wire wr_take   = WRITE & ~WAITREQUEST;
  wire start     = wr_take & sel_ctrl;
  wire [31:0] ctrl_new = merge(ctrl, WRITEDATA, BYTEENABLE);
  wire [31:0] addr_new = merge({16'h0, addr_reg}, WRITEDATA, BYTEENABLE);
  wire [31:0] rd_mux   = (ADDRESS == `REG_CTRL)   ? ctrl :
                         (ADDRESS == `REG_ADDR)   ? {16'h0, addr_reg} :
                         (ADDRESS == `REG_TXDATA) ? txdata :
                         (ADDRESS == `REG_RXDATA) ? rxdata :
                         (ADDRESS == `REG_STATUS) ? {31'h0, busy} :
                         (ADDRESS == `REG_PIN)    ? {31'h0, wp_level} : 32'h0;

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      WAITREQUEST <= 1'b1;
      READDATA    <= 32'h0;
      ctrl        <= 32'h0;
      addr_reg    <= 16'h0;
      txdata      <= 32'h0;
      wp_level    <= 1'b1;
    end else begin
      WAITREQUEST <= ~accept;
      if (accept & READ) READDATA <= rd_mux;
      if (start) ctrl <= ctrl_new;
      if (wr_take & ADDRESS == `REG_ADDR) addr_reg <= addr_new[15:0];
      if (wr_take & ADDRESS == `REG_TXDATA) txdata <= merge(txdata, WRITEDATA, BYTEENABLE);
      if (wr_take & ADDRESS == `REG_PIN & BYTEENABLE[0]) wp_level <= WRITEDATA[0];
    end
  end

  // ****************************************************************
  // Serial engine, mode 0
  // ****************************************************************
  eeprom_pkg::host_state_t state;
  logic [1:0]  so_sync;
  logic [7:0]  div;
  logic [5:0]  bits;
  logic [55:0] tx;
  logic [31:0] rx;
  logic        cs_n;
  logic        sck;
  logic        si;

  wire       half_done = div == 8'(HALF - 1);
  wire [2:0] nbytes    = ctrl_new[`CTRL_CNT_MSB:`CTRL_CNT_LSB];
  wire       with_addr = ctrl_new[`CTRL_ADDR_EN];
  wire [5:0] nbits     = 6'h08 + (with_addr ? 6'h10 : 6'h00) + {nbytes, 3'h0};

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state   <= eeprom_pkg::H_IDLE;
      so_sync <= 2'h3;
      div     <= 8'h0;
      bits    <= 6'h0;
      tx      <= 56'h0;
      rx      <= 32'h0;
      rxdata  <= 32'h0;
      busy    <= 1'b0;
      cs_n    <= 1'b1;
      sck     <= 1'b0;
      si      <= 1'b0;
    end else begin
      so_sync <= {so_sync[0], LINK.so_line};
      div     <= (state == eeprom_pkg::H_IDLE | half_done) ? 8'h0 : div + 8'h1;
      unique case (state)
        eeprom_pkg::H_IDLE: begin
          if (start) begin
            busy  <= 1'b1;
            cs_n  <= 1'b0;
            bits  <= nbits;
            tx    <= with_addr ? {ctrl_new[7:0], addr_reg, txdata}
                               : {ctrl_new[7:0], txdata, 16'h0};
            state <= eeprom_pkg::H_LEAD;
          end
        end
        eeprom_pkg::H_LEAD: begin
          if (half_done) begin
            si    <= tx[55];
            state <= eeprom_pkg::H_LOW;
          end
        end
        eeprom_pkg::H_LOW: begin
          if (half_done) begin
            sck   <= 1'b1;
            rx    <= {rx[30:0], so_sync[1]};
            state <= eeprom_pkg::H_HIGH;
          end
        end
        eeprom_pkg::H_HIGH: begin
          if (half_done) begin
            sck  <= 1'b0;
            tx   <= {tx[54:0], 1'b0};
            bits <= bits - 6'h1;
            si   <= tx[54];
            state <= (bits == 6'h1) ? eeprom_pkg::H_TRAIL : eeprom_pkg::H_LOW;
          end
        end
        eeprom_pkg::H_TRAIL: begin
          if (half_done) begin
            cs_n   <= 1'b1;
            rxdata <= rx;
            state  <= eeprom_pkg::H_GAP;
          end
        end
        eeprom_pkg::H_GAP: begin
          if (half_done) begin
            busy  <= 1'b0;
            state <= eeprom_pkg::H_IDLE;
          end
        end
        default: state <= eeprom_pkg::H_IDLE;
      endcase
    end
  end

  assign LINK.cs_n = cs_n;
  assign LINK.sck  = sck;
  assign LINK.si   = si;
  assign LINK.wp_n = wp_level;
endmodule : spi_host

/* File: verification/spi_link_props.sv */
// Concurrent checks on the link between the controller and the serial EEPROM.
module spi_link_props #(
  parameter int unsigned PROG_CYCLES = 1000
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic so_line,
  input wire logic PROG_BUSY
);
  // ****************************************************************
  // Link and busy-cycle properties
  // ****************************************************************
  int unsigned busy_len;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  // The busy length is counted here because it is far too long for a repetition.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET)
      busy_len <= 0;
    else
      busy_len <= PROG_BUSY ? busy_len + 1 : 0;
  end

  sequence desel6;
    cs_n [*6];
  endsequence
  sequence gap16;
    cs_n [*8] ##1 cs_n [*8];
  endsequence

  so_float_a: assert property (desel6 |-> !so_oe)
    else $error("data out driven while deselected");
  busy_len_a: assert property ($fell(PROG_BUSY) |->
      busy_len + 1 >= PROG_CYCLES && busy_len <= PROG_CYCLES + 1)
    else $error("programming cycle has the wrong length");
  busy_start_a: assert property ($rose(PROG_BUSY) |-> cs_n && $past(cs_n, 2))
    else $error("programming began while selected");
  sck_idle_a: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("shift clock not idle low between frames");
  si_hold_a: assert property (sck && $past(sck) |-> $stable(si))
    else $error("data in changed while shift clock high");
  cs_gap_a: assert property ($rose(cs_n) |-> gap16)
    else $error("deselect gap too short");
  so_shift_a: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
    else $error("data out changed while shift clock high");
  cs_fall_a: assert property ($fell(cs_n) |-> !sck)
    else $error("select fell with shift clock high");
  cs_rise_a: assert property ($rose(cs_n) |-> !sck)
    else $error("select rose with shift clock high");
  sck_frame_a: assert property ($rose(sck) |-> !cs_n)
    else $error("shift clock pulsed outside a frame");
  busy_ones_a: assert property (PROG_BUSY && so_oe |-> so_line)
    else $error("data out not all ones during programming");
endmodule : spi_link_props

/* File: verification/spi_eeprom_access_protect_test.sv */
// Bench joining controller and EEPROM, driven over the register bus against a model.
`include "eeprom_params.svh"

module spi_eeprom_access_protect_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Signals, model state and instances
  // ****************************************************************
  localparam int unsigned PROG = 2000;
  logic        REF_CLK   = 1'b0;
  logic        RESET     = 1'b1;
  logic [4:0]  ADDRESS   = 5'h00;
  logic        READ      = 1'b0;
  logic        WRITE     = 1'b0;
  logic [31:0] WRITEDATA = 32'h0;
  logic [31:0] READDATA;
  logic        WAITREQUEST;
  logic        PROG_BUSY;
  int          fails = 0;
  int          samples_checked = 0;
  logic [7:0]  mem [int];
  logic        latch = 1'b0;
  logic        protect_pin_enable = 1'b0;
  logic        busy = 1'b0;
  logic        wp_pin = 1'b1;
  logic [1:0]  bp = 2'h0;
  logic [31:0] q;

  spi_link_if link ();
  spi_host spi_host_i (.REF_CLK(REF_CLK), .RESET(RESET), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(4'hF), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .LINK(link));
  eeprom_device #(.PROG_CYCLES(PROG)) eeprom_device_i (.REF_CLK(REF_CLK), .RESET(RESET),
    .LINK(link), .PROG_BUSY(PROG_BUSY));
  spi_link_props #(.PROG_CYCLES(PROG)) spi_link_props_i (.REF_CLK(REF_CLK), .RESET(RESET),
    .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .wp_n(link.wp_n), .so(link.so),
    .so_oe(link.so_oe), .so_line(link.so_line), .PROG_BUSY(PROG_BUSY));

  always #2 REF_CLK = ~REF_CLK;

  task automatic wrap_up();
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic tmo();
    fails++;
    wrap_up();
  endtask : tmo

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // A write to the control register stalls while a frame is running, hence the wide bound.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    WRITE <= wr;
    READ <= ~wr;
    ADDRESS <= a;
    WRITEDATA <= d;
    @(posedge REF_CLK);
    while (WAITREQUEST !== 1'b0) begin
      if (++n > 4000) tmo();
      @(posedge REF_CLK);
    end
    q = READDATA;
    WRITE <= 1'b0;
    READ <= 1'b0;
    @(posedge REF_CLK);
  endtask : bus

  task automatic xfer(input logic [7:0] o, input logic ae, input logic [2:0] n,
                      input logic [15:0] ad, input logic [31:0] d);
    int k;
    k = 0;
    bus(1'b1, `REG_ADDR, {16'h0, ad});
    bus(1'b1, `REG_TXDATA, d);
    bus(1'b1, `REG_CTRL, {20'h0, n, ae, o});
    do begin
      bus(1'b0, `REG_STATUS, 32'h0);
      if (++k > 1000) tmo();
    end while (q[0] !== 1'b0);
    bus(1'b0, `REG_RXDATA, 32'h0);
  endtask : xfer

  task automatic wait_ready();
    int k;
    for (k = 0; k < 40; k++) begin
      xfer(8'h05, 1'b0, 3'h1, 16'h0, 32'h0);
      if (q[0] === 1'b0) break;
    end
    if (k == 40) tmo();
    busy = 1'b0;
  endtask : wait_ready

  // One command in its own frame; the model is updated only when the device is idle.
  task automatic op(input logic [2:0] c, input logic [15:0] ad, input logic [2:0] n,
                    input logic [31:0] d, input logic nw);
    int i;
    logic [9:0] a;
    logic [31:0] e;
    xfer({4'h0, 1'($urandom), c}, c == 3'h3 || c == 3'h2, n, ad, d);
    for (i = 0; i < n; i++) begin
      a = 10'(ad) + 10'(i);
      if (c == 3'h3 && (busy || mem.exists(a))) begin
        e = busy ? 32'hFF : 32'(mem[a]);
        chk("array byte", e, 32'(q[8*(n-1-i) +: 8]));
      end
    end
    if (c == 3'h5) begin
      e = busy ? 32'hFF : {24'h0, protect_pin_enable, 3'h0, bp, latch, 1'b0};
      chk("status", e, {24'h0, q[7:0]});
    end
    // A refused status write starts no cycle, so the latch stays set.
    if (!busy) begin
      if (c == 3'h6) latch = 1'b1;
      if (c == 3'h4) latch = 1'b0;
      if (c == 3'h1 && latch && !(protect_pin_enable && !wp_pin)) begin
        {protect_pin_enable, bp} = {d[31], d[27:26]};
        busy = 1'b1;
        latch = 1'b0;
      end
      if (c == 3'h2 && latch) begin
        for (i = 0; i < n; i++) begin
          a = {ad[9:5], ad[4:0] + 5'(i)};
          if (!(bp == 2'h3 || (bp == 2'h2 && a[9]) || (bp == 2'h1 && a[9:8] == 2'h3)))
            mem[a] = d[31-8*i -: 8];
        end
        busy = 1'b1;
        latch = 1'b0;
      end
    end
    if (busy && !nw) wait_ready();
  endtask : op

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int lvl;
    logic [15:0] b;
    void'($urandom(32'hF7D5));
    repeat (2) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    bus(1'b0, `REG_PIN, 32'h0);
    chk("pin register", 32'h1, {31'h0, q[0]});
    bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
    bus(1'b0, 5'h1C, 32'h0);
    chk("unmapped read", 32'h0, q);
    xfer(8'h16, 1'b0, 3'h0, 16'h0, 32'h0);
    op(3'h5, 16'h0, 3'h1, 32'h0, 1'b0);
    op(3'h6, 16'h0, 3'h0, 32'h0, 1'b0);
    op(3'h5, 16'h0, 3'h1, 32'h0, 1'b0);
    op(3'h4, 16'h0, 3'h0, 32'h0, 1'b0);
    op(3'h5, 16'h0, 3'h1, 32'h0, 1'b0);
    op(3'h6, 16'h0, 3'h0, 32'h0, 1'b0);
    op(3'h2, {6'($urandom), 10'h3FE}, 3'h4, $urandom, 1'b1);
    op(3'h5, 16'h0, 3'h1, 32'h0, 1'b1);
    op(3'h3, 16'h03FF, 3'h1, 32'h0, 1'b1);
    wait_ready();
    op(3'h5, 16'h0, 3'h1, 32'h0, 1'b0);
    for (lvl = 0; lvl < 4; lvl++) begin
      op(3'h6, 16'h0, 3'h0, 32'h0, 1'b0);
      op(3'h2, 16'(lvl << 8), 3'h2, $urandom, 1'b0);
    end
    op(3'h3, 16'h03FE, 3'h4, 32'h0, 1'b0);
    op(3'h3, 16'h03E0, 3'h2, 32'h0, 1'b0);
    op(3'h2, 16'h0100, 3'h1, $urandom, 1'b0);
    op(3'h3, 16'h0100, 3'h1, 32'h0, 1'b0);
    for (lvl = 1; lvl < 4; lvl++) begin
      b = (lvl == 1) ? 16'h0300 : (lvl == 2) ? 16'h0200 : 16'h0100;
      op(3'h6, 16'h0, 3'h0, 32'h0, 1'b0);
      op(3'h1, 16'h0, 3'h1, {4'h0, 2'(lvl), 26'h0}, 1'b0);
      op(3'h5, 16'h0, 3'h1, 32'h0, 1'b0);
      op(3'h6, 16'h0, 3'h0, 32'h0, 1'b0);
      op(3'h2, b, 3'h1, $urandom, 1'b0);
      op(3'h6, 16'h0, 3'h0, 32'h0, 1'b0);
      op(3'h2, b - 16'h1, 3'h1, $urandom, 1'b0);
      op(3'h4, 16'h0, 3'h0, 32'h0, 1'b0);
      op(3'h3, b - 16'h1, 3'h2, 32'h0, 1'b0);
    end
    op(3'h6, 16'h0, 3'h0, 32'h0, 1'b0);
    op(3'h1, 16'h0, 3'h1, 32'h8000_0000, 1'b0);
    bus(1'b1, `REG_PIN, 32'h0);
    wp_pin = 1'b0;
    op(3'h6, 16'h0, 3'h0, 32'h0, 1'b0);
    op(3'h1, 16'h0, 3'h1, 32'h0C00_0000, 1'b0);
    op(3'h5, 16'h0, 3'h1, 32'h0, 1'b0);
    op(3'h4, 16'h0, 3'h0, 32'h0, 1'b0);
    op(3'h6, 16'h0, 3'h0, 32'h0, 1'b0);
    op(3'h2, 16'h03E0, 3'h1, $urandom, 1'b0);
    op(3'h3, 16'h03E0, 3'h1, 32'h0, 1'b0);
    bus(1'b1, `REG_PIN, 32'h1);
    wp_pin = 1'b1;
    op(3'h6, 16'h0, 3'h0, 32'h0, 1'b0);
    op(3'h1, 16'h0, 3'h1, 32'h0, 1'b0);
    bus(1'b1, `REG_PIN, 32'h0);
    wp_pin = 1'b0;
    op(3'h6, 16'h0, 3'h0, 32'h0, 1'b0);
    op(3'h1, 16'h0, 3'h1, 32'h0400_0000, 1'b0);
    op(3'h5, 16'h0, 3'h1, 32'h0, 1'b0);
    wrap_up();
  end
endmodule : spi_eeprom_access_protect_test
